//--- include/input_conditioner_regs.svh
`ifndef INPUT_CONDITIONER_REGS_SVH
`define INPUT_CONDITIONER_REGS_SVH

// Timing base
`define CLK_PERIOD_NS      8
`define MS_PERIOD_NS       1000000
`define MS_CYCLES          (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define SCAN_PERIOD_MS     5
`define AC_EXTRA_MS        30

// Channel layout
`define CHANNEL_COUNT      8
`define FIRST_NUMBER_BASE  0

// Threshold scaling: one step is 0.1 V = 100 mV; AC release is 10 % of activation
`define MV_PER_STEP        100
`define AC_REL_MV_PER_STEP 10

// Setting defaults (software drives these after reset)
`define ACT_THR_DEFAULT    16'h0370
`define REL_THR_DEFAULT    16'h0258
`define DELAY_DEFAULT      21'h000000
`define POLARITY_DEFAULT   1'b0
`define AC_MODE_DEFAULT    1'b0

`endif

//--- include/input_conditioner_pkg.sv
`default_nettype none

package input_conditioner_pkg;

    typedef logic [18:0] mv_t;     // Millivolts, up to 275000
    typedef logic [15:0] thr_t;    // Threshold in 0.1 V steps
    typedef logic [20:0] ms_t;     // Delay in ms, up to 1800000
    typedef logic [21:0] dly_t;    // Delay plus AC extension
    typedef logic [31:0] count_t;  // Rising event count

    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_ARM_ON  = 4'b0010,
        ST_ON      = 4'b0100,
        ST_ARM_OFF = 4'b1000
    } phase_t;

endpackage

`default_nettype wire

//--- include/status_delay_if.sv
`timescale 1ns/1ns
`default_nettype none

interface status_delay_if;
    import input_conditioner_pkg::*;

    logic ms_tick;
    logic scan_tick;
    logic level;
    dly_t on_delay;
    dly_t off_delay;
    logic status;

    modport ctrl  (output ms_tick, scan_tick, level, on_delay, off_delay, input status);
    modport timer (input ms_tick, scan_tick, level, on_delay, off_delay, output status);
endinterface

`default_nettype wire

//--- hdl/status_delay_timer.sv
`timescale 1ns/1ns
`default_nettype none

module status_delay_timer
    import input_conditioner_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    status_delay_if.timer    dly
);

    phase_t phase_reg;
    phase_t phase_next;
    dly_t   left_reg;
    dly_t   left_next;

    ////////////////////////////////////////////////////////////////////////////
    // Pending changes count down in ms; commits only happen on a scan tick
    always_comb begin
        phase_next = phase_reg;
        left_next  = left_reg;
        if (dly.ms_tick && left_reg != '0) begin
            left_next = left_reg - dly_t'(1);
        end
        if (dly.scan_tick) begin
            unique case (phase_reg)
                ST_OFF: begin
                    if (dly.level) begin
                        phase_next = (dly.on_delay == '0) ? ST_ON : ST_ARM_ON;
                        left_next  = dly.on_delay;
                    end
                end
                ST_ARM_ON: begin
                    if (!dly.level) begin
                        phase_next = ST_OFF;
                    end else if (left_reg == '0) begin
                        phase_next = ST_ON;
                    end
                end
                ST_ON: begin
                    if (!dly.level) begin
                        phase_next = (dly.off_delay == '0) ? ST_OFF : ST_ARM_OFF;
                        left_next  = dly.off_delay;
                    end
                end
                ST_ARM_OFF: begin
                    if (dly.level) begin
                        phase_next = ST_ON;
                    end else if (left_reg == '0) begin
                        phase_next = ST_OFF;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= ST_OFF;
            left_reg  <= '0;
        end else begin
            phase_reg <= phase_next;
            left_reg  <= left_next;
        end
    end

    // Pending-off still reports 1, pending-on still reports 0
    assign dly.status = (phase_reg == ST_ON) || (phase_reg == ST_ARM_OFF);

endmodule // status_delay_timer

`default_nettype wire

//--- hdl/digital_input_conditioner.sv
`timescale 1ns/1ns
`default_nettype none
`include "input_conditioner_regs.svh"


module digital_input_conditioner
    import input_conditioner_pkg::*;
#(
    parameter int          CH           = `CHANNEL_COUNT,
    parameter int          MS_CYCLES    = `MS_CYCLES,
    parameter logic [7:0]  FIRST_NUMBER = 8'(`FIRST_NUMBER_BASE)
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire mv_t    [CH-1:0]   volt_mv_i,
    input  wire thr_t   [CH-1:0]   act_thr_i,
    input  wire thr_t   [CH-1:0]   rel_thr_i,
    input  wire logic   [CH-1:0]   polarity_inv_i,
    input  wire ms_t    [CH-1:0]   act_delay_ms_i,
    input  wire ms_t    [CH-1:0]   drop_delay_ms_i,
    input  wire logic   [CH-1:0]   alternating_supply_option_i,
    input  wire logic   [CH-1:0]   event_count_clear_i,
    output logic        [CH-1:0]   status_o,
    output count_t      [CH-1:0]   rising_event_count_o,
    output mv_t         [CH-1:0]   live_channel_voltage_o,
    output logic                   scan_tick_o,
    output logic        [7:0]      first_number_o
);

    localparam int MS_W = $clog2(MS_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Timebase: one divider makes a 1 ms enable, a small counter the scan enable

    logic [MS_W-1:0] div_reg;
    logic [MS_W-1:0] div_next;
    logic [2:0]      sub_reg;
    logic [2:0]      sub_next;
    logic            ms_tick_reg;
    logic            ms_tick_next;
    logic            scan_tick_reg;
    logic            scan_tick_next;

    always_comb begin
        div_next       = div_reg + MS_W'(1);
        sub_next       = sub_reg;
        ms_tick_next   = 1'b0;
        scan_tick_next = 1'b0;
        if (div_reg == MS_W'(MS_CYCLES - 1)) begin
            div_next     = '0;
            ms_tick_next = 1'b1;
            if (sub_reg == 3'(`SCAN_PERIOD_MS - 1)) begin
                sub_next       = '0;
                scan_tick_next = 1'b1;
            end else begin
                sub_next = sub_reg + 3'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg       <= '0;
            sub_reg       <= '0;
            ms_tick_reg   <= 1'b0;
            scan_tick_reg <= 1'b0;
        end else begin
            div_reg       <= div_next;
            sub_reg       <= sub_next;
            ms_tick_reg   <= ms_tick_next;
            scan_tick_reg <= scan_tick_next;
        end
    end

    assign scan_tick_o = scan_tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Channel numbering: the card's first channel follows earlier modules

    logic [7:0] first_number_reg;
    logic [7:0] first_number_next;

    always_comb begin
        first_number_next = FIRST_NUMBER + 8'(1);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_number_reg <= 8'h00;
        end else begin
            first_number_reg <= first_number_next;
        end
    end

    assign first_number_o = first_number_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel conditioning

    status_delay_if dly_if [CH-1:0] ();

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : gen_ch
            logic [23:0] volt_w;
            logic [23:0] act_mv;
            logic [23:0] rel_mv;
            logic        energized_reg;
            logic        energized_next;
            mv_t         live_reg;
            mv_t         live_next;
            logic        status_reg;
            logic        status_next;
            count_t      count_reg;
            count_t      count_next;

            // Thresholds in 0.1 V steps scaled to mV; widened so products cannot wrap
            always_comb begin
                volt_w = 24'(volt_mv_i[g]);
                act_mv = 24'(act_thr_i[g]) * 24'(`MV_PER_STEP);
                if (alternating_supply_option_i[g]) begin
                    rel_mv = 24'(act_thr_i[g]) * 24'(`AC_REL_MV_PER_STEP);
                end else begin
                    rel_mv = 24'(rel_thr_i[g]) * 24'(`MV_PER_STEP);
                end
            end

            // Raw energized state, sampled only on the scan enable
            always_comb begin
                energized_next = energized_reg;
                live_next      = live_reg;
                if (scan_tick_reg) begin
                    live_next = volt_mv_i[g];
                    if (volt_w > act_mv) begin
                        energized_next = 1'b1;
                    end else if (volt_w < rel_mv) begin
                        energized_next = 1'b0;
                    end
                end
            end

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    energized_reg <= 1'b0;
                    live_reg      <= '0;
                end else begin
                    energized_reg <= energized_next;
                    live_reg      <= live_next;
                end
            end

            // Inverted polarity flips the energized sense before the delays
            assign dly_if[g].level     = energized_reg ^ polarity_inv_i[g];
            assign dly_if[g].ms_tick   = ms_tick_reg;
            assign dly_if[g].scan_tick = scan_tick_reg;
            assign dly_if[g].on_delay  = dly_t'(act_delay_ms_i[g]);
            assign dly_if[g].off_delay = alternating_supply_option_i[g]
                                       ? dly_t'(drop_delay_ms_i[g]) + dly_t'(`AC_EXTRA_MS)
                                       : dly_t'(drop_delay_ms_i[g]);

            status_delay_timer u_timer (
                .clk_sys_i (clk_sys_i),
                .rst_n_i   (rst_n_i),
                .dly       (dly_if[g])
            );

            // Counting on the registered copy keeps output and count in step;
            // an edge in the clear cycle still counts so no event is lost
            always_comb begin
                status_next = dly_if[g].status;
                count_next  = count_reg;
                if (event_count_clear_i[g]) begin
                    count_next = '0;
                end
                if (dly_if[g].status && !status_reg) begin
                    count_next = count_next + count_t'(1);
                end
            end

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status_reg <= 1'b0;
                    count_reg  <= '0;
                end else begin
                    status_reg <= status_next;
                    count_reg  <= count_next;
                end
            end

            assign status_o[g]               = status_reg;
            assign rising_event_count_o[g]   = count_reg;
            assign live_channel_voltage_o[g] = live_reg;
        end
    endgenerate

endmodule // digital_input_conditioner

`default_nettype wire

//--- test/input_conditioner_checker.sv
`timescale 1ns/1ns
`default_nettype none
module input_conditioner_checker
    import input_conditioner_pkg::*;
#(
    parameter int         CH           = 8,
    parameter int         MS_CYCLES    = 4,
    parameter logic [7:0] FIRST_NUMBER = 8'h00
) (
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire mv_t    [CH-1:0]   volt_mv_i,
    input wire logic   [CH-1:0]   event_count_clear_i,
    input wire logic   [CH-1:0]   status_o,
    input wire count_t [CH-1:0]   rising_event_count_o,
    input wire mv_t    [CH-1:0]   live_channel_voltage_o,
    input wire logic              scan_tick_o,
    input wire logic   [7:0]      first_number_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    int   gap_reg, gap_next;
    logic seen_reg, seen_next;
    // Period is checked only after the first tick, whose offset from release is loose
    always_comb begin
        gap_next  = scan_tick_o ? 0 : gap_reg + 1;
        seen_next = seen_reg | scan_tick_o;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_reg  <= 0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= gap_next;
            seen_reg <= seen_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_SCAN_PERIOD: assert property (seen_reg |->
        (scan_tick_o == (gap_reg == 5 * MS_CYCLES - 1))) else $error("scan period wrong");
    AST_SCAN_PULSE: assert property (scan_tick_o |=> !scan_tick_o)
        else $error("scan tick longer than one cycle");
    AST_STATUS_ON_SCAN: assert property (!$stable(status_o) |->
        ($past(scan_tick_o) || $past(scan_tick_o, 2))) else $error("status moved off scan");
    // Count and status register on one edge, so a rise shows together with its count
    AST_COUNT_RISE: assert property ($rose(status_o[0]) |-> rising_event_count_o[0] ==
        ($past(event_count_clear_i[0]) ? 32'h1 : $past(rising_event_count_o[0]) + 32'h1))
        else $error("count missed a rise");
    AST_COUNT_CLEAR: assert property (event_count_clear_i[0] |=>
        rising_event_count_o[0] == ($rose(status_o[0]) ? 32'h1 : 32'h0))
        else $error("count not cleared");
    AST_COUNT_HOLD: assert property (!event_count_clear_i[0] |=>
        rising_event_count_o[0] == $past(rising_event_count_o[0])
        + ($rose(status_o[0]) ? 32'h1 : 32'h0)) else $error("count moved without a rise");
    AST_LIVE_VOLT: assert property (scan_tick_o |=>
        live_channel_voltage_o == $past(volt_mv_i)) else $error("live voltage not captured");
    AST_LIVE_HOLD: assert property (!scan_tick_o |=> $stable(live_channel_voltage_o))
        else $error("live voltage moved off scan");
    AST_FIRST_NUMBER: assert property ($past(rst_n_i) |->
        first_number_o == FIRST_NUMBER + 8'h01) else $error("first number wrong");
    COV_RISE: cover property ($rose(status_o[0]));
    COV_CLEAR: cover property (event_count_clear_i[0] && rising_event_count_o[0] != 32'h0);
    COV_FALL: cover property ($fell(status_o[2]));
endmodule // input_conditioner_checker
bind digital_input_conditioner input_conditioner_checker #(
    .CH(CH), .MS_CYCLES(MS_CYCLES), .FIRST_NUMBER(FIRST_NUMBER)
) chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .volt_mv_i(volt_mv_i),
    .event_count_clear_i(event_count_clear_i), .status_o(status_o),
    .rising_event_count_o(rising_event_count_o),
    .live_channel_voltage_o(live_channel_voltage_o), .scan_tick_o(scan_tick_o),
    .first_number_o(first_number_o)
);
`default_nettype wire

//--- test/field_contact_model.sv
`timescale 1ns/1ns
`default_nettype none
module field_contact_model
    import input_conditioner_pkg::*;
#(parameter int CH = 8) (
    input  wire logic         clk_sys_i,
    input  wire mv_t [CH-1:0] cmd_mv_i,
    output mv_t      [CH-1:0] volt_mv_o
);
    // Field level settles half a cycle away from the scan edge
    always @(negedge clk_sys_i) begin
        volt_mv_o <= cmd_mv_i;
    end
endmodule // field_contact_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import input_conditioner_pkg::*;
    localparam logic [7:0] FN = 8'h08;
    typedef struct {int ch; logic p; logic a; thr_t thr; mv_t mv; logic st; int sc;} row_t;
    logic            clk_sys_i, rst_n_i, tick;
    mv_t    [7:0]    cmd_mv, volt_mv, live;
    thr_t   [7:0]    act_thr, rel_thr;
    ms_t    [7:0]    act_dly, drop_dly;
    logic   [7:0]    pol, ac, clr, status, first_num;
    count_t [7:0]    count;
    int              num_errors, checks, cyc;
    row_t rows[11] = '{
        '{0, 0, 0, 16'h0370, 19'h15f90, 1, 3},
        '{0, 0, 0, 16'h0370, 19'h11170, 1, 3},
        '{0, 0, 0, 16'h0370, 19'h0e678, 0, 3},
        '{0, 0, 0, 16'h0370, 19'h157c0, 0, 3},
        '{1, 1, 0, 16'h0370, 19'h15f90, 0, 3},
        '{1, 1, 0, 16'h0370, 19'h0e678, 1, 3},
        '{2, 0, 1, 16'h0370, 19'h15f90, 1, 3},
        '{2, 0, 1, 16'h0370, 19'h02328, 1, 10},
        '{2, 0, 1, 16'h0370, 19'h01f40, 1, 3},
        '{2, 0, 1, 16'h0370, 19'h01f40, 0, 7},
        '{3, 0, 0, 16'h01f4, 19'h0ea60, 1, 3}
    };
    field_contact_model #(.CH(8)) field (.clk_sys_i(clk_sys_i), .cmd_mv_i(cmd_mv),
        .volt_mv_o(volt_mv));
    digital_input_conditioner #(.CH(8), .MS_CYCLES(4), .FIRST_NUMBER(FN)) uut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .volt_mv_i(volt_mv),
        .act_thr_i(act_thr), .rel_thr_i(rel_thr), .polarity_inv_i(pol),
        .act_delay_ms_i(act_dly), .drop_delay_ms_i(drop_dly),
        .alternating_supply_option_i(ac), .event_count_clear_i(clr), .status_o(status),
        .rising_event_count_o(count), .live_channel_voltage_o(live),
        .scan_tick_o(tick), .first_number_o(first_num));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Zero delays settle two cycles after the scan after sampling; three ticks are the fewest that suffice
    task automatic wait_scans(input int n);
        repeat (n) @(posedge tick);
        repeat (2) @(negedge clk_sys_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("Error at %0t: run hung", $time);
            end_of_test();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        cmd_mv = '0;
        act_thr = {8{16'h0370}};
        rel_thr = {8{16'h0258}};
        act_dly = '0;
        drop_dly = '0;
        pol = '0;
        ac = '0;
        clr = '0;
        repeat (3) @(negedge clk_sys_i);
        check(status, 32'h0, "status in reset");
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        check(first_num, FN + 8'h01, "first number");
        foreach (rows[i]) begin
            @(negedge clk_sys_i);
            pol[rows[i].ch] = rows[i].p;
            ac[rows[i].ch] = rows[i].a;
            act_thr[rows[i].ch] = rows[i].thr;
            cmd_mv[rows[i].ch] <= rows[i].mv;
            wait_scans(rows[i].sc);
            check(status[rows[i].ch], rows[i].st, "status row");
            check(live[rows[i].ch], rows[i].mv, "live voltage");
        end
        $display("table rows done");
        act_dly[4] = 21'h00000c;
        drop_dly[4] = 21'h00000c;
        cmd_mv[4] <= 19'h15f90;
        wait_scans(2);
        check(status[4], 1'b0, "rise too early");
        wait_scans(4);
        check(status[4], 1'b1, "rise late");
        cmd_mv[4] <= 19'h00000;
        wait_scans(2);
        check(status[4], 1'b1, "fall too early");
        wait_scans(4);
        check(status[4], 1'b0, "fall late");
        check(count[4], 32'h1, "count after one rise");
        $display("delay test done");
        check(count[0], 32'h1, "count before clear");
        clr[0] = 1'b1;
        @(negedge clk_sys_i);
        clr[0] = 1'b0;
        check(count[0], 32'h0, "count after clear");
        check(count[4], 32'h1, "other channel kept");
        $display("clear test done");
        rst_n_i = 1'b0;
        @(negedge clk_sys_i);
        check(count[4], 32'h0, "count in reset");
        check(first_num, 8'h00, "first number in reset");
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check(first_num, FN + 8'h01, "first number again");
        $display("reset test done");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
